// >>> rtl/fault_manager.sv
// The address map and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module fault_manager
  import fault_mgr_pkg::*;
#(
  parameter int unsigned OVERLOAD_FAULT_CYCLES     = OVERLOAD_FAULT_CYCLES_DFLT,
  parameter int unsigned RECOVERY_CYCLES = RECOVERY_CYCLES_DFLT,
  parameter int unsigned SCP_LIMIT       = SCP_PULSE_LIMIT
) (
  // Clock and reset
  input  wire logic                        MCLK_IN,
  input  wire logic                        RSTN_IN,
  // Controller reset sources
  input  wire logic                        SUPPLY_OFF_IN,
  input  wire logic                        PIN_RESET_IN,
  // Detector comparators
  input  wire logic                        THERMAL_HOT_IN,
  input  wire logic                        FAULT_PIN_LOW_IN,
  input  wire logic                        FAULT_PIN_REC_IN,
  input  wire logic                        FAULT_PIN_HIGH_IN,
  input  wire logic                        SUPPLY_OVP_IN,
  input  wire logic                        SS_ABOVE_IN,
  // Pulse modulator
  input  wire logic                        PWM_REQ_IN,
  input  wire logic                        CUR_LIMIT_TERM_IN,
  input  wire logic                        SHORT_TRIP_IN,
  input  wire logic                        PULSE_END_IN,
  // Driver and bias
  output logic                             GATE_DRIVE_OUTPUT_OUT,
  output logic                             LOW_POWER_OUT,
  output logic                             FAULT_MODE_OUT,
  // AHB-Lite slave
  input  wire logic                        HSEL_IN,
  input  wire logic [31:0]                 HADDR_IN,
  input  wire logic [1:0]                  HTRANS_IN,
  input  wire logic                        HWRITE_IN,
  input  wire logic [2:0]                  HSIZE_IN,
  input  wire logic [31:0]                 HWDATA_IN,
  input  wire logic                        HREADY_IN,
  output logic [31:0]                      HRDATA_OUT,
  output logic                             HREADYOUT_OUT,
  output logic                             HRESP_OUT
);

  import fault_mgr_pkg::*;

  localparam int unsigned OW = $clog2(OVERLOAD_FAULT_CYCLES + 1);
  localparam int unsigned RW = $clog2(RECOVERY_CYCLES + 1);
  localparam int unsigned SW = $clog2(SCP_LIMIT + 1);
  localparam logic [OW-1:0] OVERLOAD_FAULT_LAST = OW'(OVERLOAD_FAULT_CYCLES - 1);
  localparam logic [RW-1:0] REC_LAST  = RW'(RECOVERY_CYCLES - 1);
  localparam logic [SW-1:0] SCP_LAST  = SW'(SCP_LIMIT - 1);

  if (OVERLOAD_FAULT_CYCLES < 2 || RECOVERY_CYCLES < 2 || SCP_LIMIT < 1) begin : g_chk
    $error("fault_manager: counts too small for the counters");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    mode_t                 mode;
    logic [NUM_FAULTS-1:0] cause;
    logic [NUM_FAULTS-1:0] events;
    logic [1:0]            ctrl;
    logic                  ss_done;
    logic [OW-1:0]         overload_fault_cnt;
    logic                  overload_fault_decl;
    logic [SW-1:0]         scp_cnt;
    logic                  scp_decl;
    logic [RW-1:0]         rec_cnt;
    logic                  rec_done;
    logic                  kill;
    logic                  drive;
    logic                  wr_pend;
    logic [RADDR_W-1:0]    addr;
    logic [31:0]           rdata;
  } fm_t;

  fm_t fm_r;
  fm_t fm_nxt;

  logic [NUM_FILTERS-1:0] filt_in;
  logic [NUM_FILTERS-1:0] filt_out;
  logic [NUM_FAULTS-1:0]  detect;
  logic [NUM_FAULTS-1:0]  latching;
  logic [NUM_FAULTS-1:0]  release_ok;
  logic                   ahb_sel;
  logic                   ctl_reset;

  ////////////////////////////////////////////////////////////////////////////////
  // Deglitch filters

  assign filt_in[FILT_OTP]    = FAULT_PIN_LOW_IN && fm_r.ss_done;
  assign filt_in[FILT_OVP]    = FAULT_PIN_HIGH_IN;
  assign filt_in[FILT_SUPOVP] = SUPPLY_OVP_IN;

  for (genvar i = 0; i < NUM_FILTERS; i++) begin : g_filt
    deglitch_filter #(
      .COUNT        (FILT_CYCLES[i])
    ) u_filt (
      .MCLK_IN      (MCLK_IN),
      .RSTN_IN      (RSTN_IN),
      .LEVEL_IN     (filt_in[i]),
      .DECLARED_OUT (filt_out[i])
    );
  end

  always_comb begin
    detect             = '0;
    detect[FI_TSD]     = THERMAL_HOT_IN;
    detect[FI_OTP]     = filt_out[FILT_OTP];
    detect[FI_OVP]     = filt_out[FILT_OVP];
    detect[FI_OVERLOAD_FAULT]    = fm_r.overload_fault_decl;
    detect[FI_SCP]     = fm_r.scp_decl;
    detect[FI_SUPOVP]  = filt_out[FILT_SUPOVP];
  end

  always_comb begin
    latching             = '0;
    latching[FI_SUPOVP]  = 1'b1;
    latching[FI_OTP]     = fm_r.ctrl[CTRL_OTP_LATCH_BIT];
    latching[FI_OVP]     = fm_r.ctrl[CTRL_OVP_LATCH_BIT];
  end

  always_comb begin
    release_ok             = '0;
    release_ok[FI_TSD]     = !THERMAL_HOT_IN;
    release_ok[FI_OTP]     = fm_r.rec_done && FAULT_PIN_REC_IN;
    release_ok[FI_OVP]     = fm_r.rec_done;
    release_ok[FI_OVERLOAD_FAULT]    = fm_r.rec_done;
    release_ok[FI_SCP]     = fm_r.rec_done;
    release_ok[FI_SUPOVP]  = 1'b0;
  end

  assign ahb_sel   = HSEL_IN && HREADY_IN && HTRANS_IN[1];
  assign ctl_reset = SUPPLY_OFF_IN || PIN_RESET_IN;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    fm_nxt = fm_r;

    if (fm_r.mode == MODE_RUN && SS_ABOVE_IN) begin
      fm_nxt.ss_done = 1'b1;
    end

    if (fm_r.mode == MODE_RUN && CUR_LIMIT_TERM_IN && !fm_r.overload_fault_decl) begin
      if (fm_r.overload_fault_cnt == OVERLOAD_FAULT_LAST) begin
        fm_nxt.overload_fault_decl = 1'b1;
      end else begin
        fm_nxt.overload_fault_cnt = fm_r.overload_fault_cnt + 1'b1;
      end
    end

    if (fm_r.mode == MODE_RUN && SHORT_TRIP_IN && !fm_r.scp_decl) begin
      if (fm_r.scp_cnt == SCP_LAST) begin
        fm_nxt.scp_decl = 1'b1;
      end else begin
        fm_nxt.scp_cnt = fm_r.scp_cnt + 1'b1;
      end
    end else if (PULSE_END_IN && !SHORT_TRIP_IN) begin
      fm_nxt.scp_cnt = '0;
    end

    if (SHORT_TRIP_IN) begin
      fm_nxt.kill = 1'b1;
    end else if (!PWM_REQ_IN) begin
      fm_nxt.kill = 1'b0;
    end

    if (fm_r.mode == MODE_FAULT && !fm_r.rec_done) begin
      if (fm_r.rec_cnt == REC_LAST) begin
        fm_nxt.rec_done = 1'b1;
      end else begin
        fm_nxt.rec_cnt = fm_r.rec_cnt + 1'b1;
      end
    end

    unique case (fm_r.mode)
      MODE_RUN: begin
        if (|detect) begin
          fm_nxt.cause = detect;
          fm_nxt.mode  = (|(detect & latching)) ? MODE_LATCHED : MODE_FAULT;
        end
      end
      MODE_FAULT: begin
        if (|(detect & latching)) begin
          fm_nxt.cause = fm_r.cause | detect;
          fm_nxt.mode  = MODE_LATCHED;
        end else if (|(detect & ~fm_r.cause)) begin
          fm_nxt.cause    = fm_r.cause | detect;
          fm_nxt.rec_cnt  = '0;
          fm_nxt.rec_done = 1'b0;
        end else if (&(release_ok | ~fm_r.cause)) begin
          if (|detect) begin
            fm_nxt.cause    = detect;
            fm_nxt.rec_cnt  = '0;
            fm_nxt.rec_done = 1'b0;
          end else begin
            fm_nxt.mode  = MODE_RUN;
            fm_nxt.cause = '0;
          end
        end
      end
      MODE_LATCHED: begin
        fm_nxt.cause = fm_r.cause | detect;
      end
      default: begin
        fm_nxt.mode = MODE_LATCHED;
      end
    endcase

    // Entry clears the counters and forces a fresh soft-start
    if (fm_r.mode == MODE_RUN && fm_nxt.mode != MODE_RUN) begin
      fm_nxt.overload_fault_cnt  = '0;
      fm_nxt.overload_fault_decl = 1'b0;
      fm_nxt.scp_cnt   = '0;
      fm_nxt.scp_decl  = 1'b0;
      fm_nxt.ss_done   = 1'b0;
      fm_nxt.rec_cnt   = '0;
      fm_nxt.rec_done  = 1'b0;
    end

    if (ctl_reset) begin
      fm_nxt.mode      = MODE_RUN;
      fm_nxt.cause     = '0;
      fm_nxt.overload_fault_cnt  = '0;
      fm_nxt.overload_fault_decl = 1'b0;
      fm_nxt.scp_cnt   = '0;
      fm_nxt.scp_decl  = 1'b0;
      fm_nxt.rec_cnt   = '0;
      fm_nxt.rec_done  = 1'b0;
      fm_nxt.ss_done   = 1'b0;
    end

    fm_nxt.drive = PWM_REQ_IN && !SHORT_TRIP_IN && !fm_nxt.kill && !ctl_reset &&
                   fm_r.mode == MODE_RUN && fm_nxt.mode == MODE_RUN;

    // Bus data phase; write-one-to-clear loses to a new event
    if (fm_r.wr_pend) begin
      unique case (fm_r.addr)
        CTRL_OFS:  fm_nxt.ctrl   = HWDATA_IN[1:0];
        EVENT_OFS: fm_nxt.events = fm_r.events & ~HWDATA_IN[NUM_FAULTS-1:0];
        default:   fm_nxt.ctrl   = fm_r.ctrl;
      endcase
    end
    fm_nxt.events = fm_nxt.events | detect;

    // Bus address phase; read data is built here so it leaves a flop
    fm_nxt.wr_pend = ahb_sel && HWRITE_IN;
    fm_nxt.addr    = HADDR_IN[RADDR_W-1:0];
    fm_nxt.rdata   = RDATA_ZERO;
    if (ahb_sel && !HWRITE_IN) begin
      unique case (HADDR_IN[RADDR_W-1:0])
        CTRL_OFS: begin
          fm_nxt.rdata[1:0] = fm_r.ctrl;
        end
        STATUS_OFS: begin
          fm_nxt.rdata[ST_CAUSE_LSB +: NUM_FAULTS] = fm_r.cause;
          fm_nxt.rdata[ST_FAULT_BIT] = (fm_r.mode != MODE_RUN);
          fm_nxt.rdata[ST_LATCH_BIT] = (fm_r.mode == MODE_LATCHED);
          fm_nxt.rdata[ST_SS_BIT]    = fm_r.ss_done;
          fm_nxt.rdata[ST_DRIVE_BIT] = fm_r.drive;
        end
        EVENT_OFS: begin
          fm_nxt.rdata[NUM_FAULTS-1:0] = fm_r.events;
        end
        default: begin
          fm_nxt.rdata = RDATA_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      fm_r      <= '0;
      fm_r.mode <= MODE_RUN;
      fm_r.ctrl <= CTRL_RESET;
    end else begin
      fm_r <= fm_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign GATE_DRIVE_OUTPUT_OUT = fm_r.drive;
  assign LOW_POWER_OUT         = (fm_r.mode != MODE_RUN);
  assign FAULT_MODE_OUT        = (fm_r.mode != MODE_RUN);
  // Zero-wait slave; size is ignored since only whole words are mapped
  assign HRDATA_OUT            = fm_r.rdata;
  assign HREADYOUT_OUT         = 1'b1;
  assign HRESP_OUT             = HRESP_OKAY;

endmodule : fault_manager

// >>> rtl/fault_mgr_pkg.sv
package fault_mgr_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Fault detector indices
  localparam int unsigned NUM_FAULTS = 6;
  localparam int unsigned FI_TSD     = 0;
  localparam int unsigned FI_OTP     = 1;
  localparam int unsigned FI_OVP     = 2;
  localparam int unsigned FI_OVERLOAD_FAULT    = 3;
  localparam int unsigned FI_SCP     = 4;
  localparam int unsigned FI_SUPOVP  = 5;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned      CLK_PERIOD_PS    = 8000;
  localparam int unsigned      OTP_FILTER_NS    = 20000;
  localparam int unsigned      OVP_FILTER_NS    = 5000;
  localparam int unsigned      SUPOVP_FILTER_NS = 3000;
  localparam int unsigned      OVERLOAD_FAULT_TIME_MS     = 30;
  localparam int unsigned      RECOVERY_TIME_MS = 1000;
  localparam longint unsigned  PS_PER_NS        = 64'd1000;
  localparam longint unsigned  PS_PER_MS        = 64'd1_000_000_000;

  // Filter delay is a least time, so round up
  function automatic int unsigned ns_to_cycles_up(input int unsigned ns);
    return int'((longint'(ns) * PS_PER_NS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  endfunction : ns_to_cycles_up

  localparam int unsigned NUM_FILTERS = 3;
  localparam int unsigned FILT_OTP    = 0;
  localparam int unsigned FILT_OVP    = 1;
  localparam int unsigned FILT_SUPOVP = 2;
  localparam int unsigned FILT_CYCLES [NUM_FILTERS] = '{
    ns_to_cycles_up(OTP_FILTER_NS),
    ns_to_cycles_up(OVP_FILTER_NS),
    ns_to_cycles_up(SUPOVP_FILTER_NS)
  };

  localparam int unsigned OVERLOAD_FAULT_CYCLES_DFLT =
    int'((longint'(OVERLOAD_FAULT_TIME_MS) * PS_PER_MS) / CLK_PERIOD_PS);
  localparam int unsigned RECOVERY_CYCLES_DFLT =
    int'((longint'(RECOVERY_TIME_MS) * PS_PER_MS) / CLK_PERIOD_PS);
  localparam int unsigned SCP_PULSE_LIMIT = 4;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam int unsigned RADDR_W    = 8;
  localparam logic [7:0]  CTRL_OFS   = 8'h00;
  localparam logic [7:0]  STATUS_OFS = 8'h04;
  localparam logic [7:0]  EVENT_OFS  = 8'h08;

  localparam int unsigned CTRL_OTP_LATCH_BIT = 0;
  localparam int unsigned CTRL_OVP_LATCH_BIT = 1;
  localparam logic [1:0]  CTRL_RESET         = 2'h0;

  localparam int unsigned ST_CAUSE_LSB = 0;
  localparam int unsigned ST_FAULT_BIT = 6;
  localparam int unsigned ST_LATCH_BIT = 7;
  localparam int unsigned ST_SS_BIT    = 8;
  localparam int unsigned ST_DRIVE_BIT = 9;

  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic        HRESP_OKAY    = 1'b0;
  localparam logic [31:0] RDATA_ZERO    = 32'h0000_0000;

  typedef enum logic [1:0] {
    MODE_RUN     = 2'b00,
    MODE_FAULT   = 2'b01,
    MODE_LATCHED = 2'b10
  } mode_t;

endpackage : fault_mgr_pkg

// >>> rtl/deglitch_filter.sv
`timescale 1ns/1ps
module deglitch_filter #(
  parameter int unsigned COUNT = 8
) (
  // Clock and reset
  input  wire logic MCLK_IN,
  input  wire logic RSTN_IN,
  // Comparator level and filtered result
  input  wire logic LEVEL_IN,
  output logic      DECLARED_OUT
);

  localparam int unsigned CW = $clog2(COUNT + 1);
  localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          decl;
  } filt_t;

  filt_t filt_r;
  filt_t filt_nxt;

  if (COUNT < 1) begin : g_chk
    $error("deglitch_filter: COUNT must be at least 1");
  end

  // Any drop of the comparator restarts the count
  always_comb begin
    filt_nxt = filt_r;
    if (!LEVEL_IN) begin
      filt_nxt.cnt  = '0;
      filt_nxt.decl = 1'b0;
    end else if (filt_r.cnt == LAST) begin
      filt_nxt.decl = 1'b1;
    end else begin
      filt_nxt.cnt = filt_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      filt_r <= '0;
    end else begin
      filt_r <= filt_nxt;
    end
  end

  assign DECLARED_OUT = filt_r.decl;

endmodule : deglitch_filter

// >>> dv/fault_manager_checker.sv
`timescale 1ns/1ps
module fault_manager_checker
  import fault_mgr_pkg::*;
#(
  parameter int unsigned OVERLOAD_FAULT_CYCLES     = OVERLOAD_FAULT_CYCLES_DFLT,
  parameter int unsigned RECOVERY_CYCLES = RECOVERY_CYCLES_DFLT
) (
  // Clock and reset
  input wire logic MCLK_IN,
  input wire logic RSTN_IN,
  // Controller reset sources, detector and modulator inputs
  input wire logic SUPPLY_OFF_IN,
  input wire logic PIN_RESET_IN,
  input wire logic THERMAL_HOT_IN,
  input wire logic SUPPLY_OVP_IN,
  input wire logic PWM_REQ_IN,
  input wire logic CUR_LIMIT_TERM_IN,
  input wire logic SHORT_TRIP_IN,
  input wire logic PULSE_END_IN,
  // Driver and bias
  input wire logic GATE_DRIVE_OUTPUT_OUT,
  input wire logic LOW_POWER_OUT,
  input wire logic FAULT_MODE_OUT
);
  typedef struct packed {
    logic [31:0] sup;
    logic [31:0] overload_fault;
    logic [31:0] fault_pin;
    logic [2:0]  trips;
    logic        hot;
  } chk_state_t;

  chk_state_t st_r;
  chk_state_t st_nxt;
  logic       ctl_rst;

  assign ctl_rst = SUPPLY_OFF_IN | PIN_RESET_IN;

  // Thermal faults release on the indication, so they are kept out of the timer check
  always_comb begin
    st_nxt      = st_r;
    st_nxt.sup  = SUPPLY_OVP_IN ? st_r.sup + 32'h0000_0001 : '0;
    st_nxt.fault_pin  = FAULT_MODE_OUT ? st_r.fault_pin + 32'h0000_0001 : '0;
    st_nxt.hot  = FAULT_MODE_OUT & (st_r.hot | THERMAL_HOT_IN);
    st_nxt.overload_fault = FAULT_MODE_OUT ? '0 : st_r.overload_fault + {31'h0000_0000, CUR_LIMIT_TERM_IN};
    if (PULSE_END_IN) begin
      st_nxt.trips = SHORT_TRIP_IN ? st_r.trips + 3'h1 : '0;
    end
    if (FAULT_MODE_OUT | ctl_rst) begin
      st_nxt.trips = '0;
    end
    if (ctl_rst) begin
      st_nxt.sup  = '0;
      st_nxt.overload_fault = '0;
    end
  end

  always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (!RSTN_IN);

  sequence s_fourth_trip;
    st_r.trips == 3'h3 && SHORT_TRIP_IN && PULSE_END_IN && !ctl_rst;
  endsequence
  sequence s_trip_then_req;
    SHORT_TRIP_IN ##1 PWM_REQ_IN;
  endsequence
  sequence s_fault_settled;
    FAULT_MODE_OUT [*2];
  endsequence

  AST_FAULT_NO_DRIVE: assert property (s_fault_settled |-> !GATE_DRIVE_OUTPUT_OUT)
    else $error("Gate drive active in fault mode");
  AST_LOW_BIAS: assert property (LOW_POWER_OUT == FAULT_MODE_OUT)
    else $error("Low power output differs from fault mode");
  AST_CTL_RESET: assert property (ctl_rst |=> !FAULT_MODE_OUT)
    else $error("Controller reset left fault mode set");
  AST_THERMAL: assert property (THERMAL_HOT_IN && !ctl_rst |=> FAULT_MODE_OUT)
    else $error("Thermal indication without fault mode");
  AST_SHORT_FOUR: assert property (s_fourth_trip |-> ##[1:3] FAULT_MODE_OUT)
    else $error("Fourth short trip did not enter fault mode");
  AST_TRIP_ENDS: assert property (s_trip_then_req |=> !GATE_DRIVE_OUTPUT_OUT)
    else $error("Drive resumed after short trip");
  AST_OVERLOAD_FAULT: assert property (st_r.overload_fault == OVERLOAD_FAULT_CYCLES && !ctl_rst |-> ##[0:3] FAULT_MODE_OUT)
    else $error("Overload time reached without fault mode");
  AST_SUP_FILTER: assert property (st_r.sup == FILT_CYCLES[FILT_SUPOVP] && !ctl_rst
      |-> ##[0:3] FAULT_MODE_OUT)
    else $error("Supply overvoltage filter expired without fault mode");
  AST_REC_MIN: assert property ($fell(FAULT_MODE_OUT) && !$past(ctl_rst) && !st_r.hot
      |-> st_r.fault_pin >= RECOVERY_CYCLES)
    else $error("Fault mode left before recovery period");
endmodule : fault_manager_checker

bind fault_manager fault_manager_checker #(
  .OVERLOAD_FAULT_CYCLES    (OVERLOAD_FAULT_CYCLES),
  .RECOVERY_CYCLES(RECOVERY_CYCLES)
) fault_manager_checker_inst (
  .MCLK_IN, .RSTN_IN, .SUPPLY_OFF_IN, .PIN_RESET_IN, .THERMAL_HOT_IN, .SUPPLY_OVP_IN,
  .PWM_REQ_IN, .CUR_LIMIT_TERM_IN, .SHORT_TRIP_IN, .PULSE_END_IN,
  .GATE_DRIVE_OUTPUT_OUT, .LOW_POWER_OUT, .FAULT_MODE_OUT
);

// >>> dv/analog_front_model.sv
`timescale 1ns/1ps
module analog_front_model (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  // Analog levels and load setup
  input  wire logic [15:0] pin_mv_in,
  input  wire logic [15:0] temp_c_in,
  input  wire logic [15:0] ss_mv_in,
  input  wire logic        short_en_in,
  input  wire logic        ilim_en_in,
  input  wire logic        drive_in,
  // Comparators and modulator
  output logic             hot_out,
  output logic             pin_low_out,
  output logic             pin_rec_out,
  output logic             pin_high_out,
  output logic             ss_above_out,
  output logic             pwm_req_out,
  output logic             cur_lim_out,
  output logic             trip_out,
  output logic             pulse_end_out
);
  typedef struct packed {
    logic [2:0] ph;
    logic       hot;
  } front_state_t;

  front_state_t st_r;
  front_state_t st_nxt;
  logic         end_ev;

  assign pin_low_out  = pin_mv_in < 16'h01F4;
  assign pin_rec_out  = pin_mv_in > 16'h0384;
  assign pin_high_out = pin_mv_in > 16'h0BB8;
  assign ss_above_out = ss_mv_in > 16'h0BB8;
  assign hot_out      = st_r.hot;
  // Request stays up past the trip so a resumed drive would show
  assign pwm_req_out  = st_r.ph < 3'h5;
  assign end_ev       = (st_r.ph == 3'h2) & drive_in;
  assign pulse_end_out = end_ev;
  assign trip_out      = end_ev & short_en_in;
  assign cur_lim_out   = end_ev & ilim_en_in;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.ph = st_r.ph + 3'h1;
    if (temp_c_in > 16'h00A5) begin
      st_nxt.hot = 1'b1;
    end else if (temp_c_in <= 16'h008C) begin
      st_nxt.hot = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : analog_front_model

// >>> dv/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, ex, ac) begin comparisons++; if ((ac) !== (ex)) begin bad_count++; \
  $display("BAD %s exp %0h seen %0h", nm, ex, ac); end end
module tb_top;
  import fault_mgr_pkg::*;
  localparam int REC  = 50;
  localparam int OVERLOAD_FAULT = 20;

  logic clk = 1'b0, rstn = 1'b0, sup_off = 1'b0, pin_rst = 1'b0, sup_ovp = 1'b0;
  logic short_en = 1'b0, ilim_en = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [15:0] pin_mv = 16'h05DC, temp_c = 16'h0019, ss_mv = 16'h0000;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
  logic hot, plo, prec, phi, ssa, pwm, clim, trip, pend, drive, lowp, fmode, hready, hresp;
  int bad_count = 0, comparisons = 0;

  always #4 clk = ~clk;

  fault_manager #(.OVERLOAD_FAULT_CYCLES(OVERLOAD_FAULT), .RECOVERY_CYCLES(REC)) fault_manager_inst (
    .MCLK_IN(clk), .RSTN_IN(rstn), .SUPPLY_OFF_IN(sup_off), .PIN_RESET_IN(pin_rst),
    .THERMAL_HOT_IN(hot), .FAULT_PIN_LOW_IN(plo), .FAULT_PIN_REC_IN(prec),
    .FAULT_PIN_HIGH_IN(phi), .SUPPLY_OVP_IN(sup_ovp), .SS_ABOVE_IN(ssa),
    .PWM_REQ_IN(pwm), .CUR_LIMIT_TERM_IN(clim), .SHORT_TRIP_IN(trip), .PULSE_END_IN(pend),
    .GATE_DRIVE_OUTPUT_OUT(drive), .LOW_POWER_OUT(lowp), .FAULT_MODE_OUT(fmode),
    .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite),
    .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata),
    .HREADYOUT_OUT(hready), .HRESP_OUT(hresp));

  analog_front_model analog_front_model_inst (
    .clk_in(clk), .rstn_in(rstn), .pin_mv_in(pin_mv), .temp_c_in(temp_c), .ss_mv_in(ss_mv),
    .short_en_in(short_en), .ilim_en_in(ilim_en), .drive_in(drive), .hot_out(hot),
    .pin_low_out(plo), .pin_rec_out(prec), .pin_high_out(phi), .ss_above_out(ssa),
    .pwm_req_out(pwm), .cur_lim_out(clim), .trip_out(trip), .pulse_end_out(pend));

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic wait_fm(input logic v, input int lim, output int n);
    n = 0;
    while (fmode !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (fmode !== v) begin
      bad_count++;
      $display("BAD fault_wait exp %0h seen %0h", v, fmode);
      give_verdict();
    end
  endtask : wait_fm

  task automatic pulse_rst(input logic pin);
    if (pin) pin_rst <= 1'b1;
    else sup_off <= 1'b1;
    cyc(1);
    pin_rst <= 1'b0;
    sup_off <= 1'b0;
    cyc(2);
  endtask : pulse_rst

  // One single AHB-Lite transfer; hready is the only slave's hreadyout
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    int lost = 0;
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr  <= {24'h00_0000, a};
    hwrite <= wr;
    for (k = 0; k == 0 || (hready !== 1'b1 && k < 20); k++) @(posedge clk);
    lost += (k >= 20);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    for (k = 0; k == 0 || (hready !== 1'b1 && k < 20); k++) @(posedge clk);
    lost += (k >= 20);
    rd = hrdata;
    `CHK("hresp", HRESP_OKAY, hresp)
    // A slave that never answers counts as a mismatch
    if (lost != 0) begin
      bad_count++;
      $display("BAD bus_wait exp %0h seen %0h", 0, lost);
      give_verdict();
    end
  endtask : bus

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_otp();
    int n;
    pin_mv <= 16'h00C8;
    cyc(3000);
    `CHK("otp_blank", 1'b0, fmode)
    pin_mv <= 16'h05DC;
    ss_mv  <= 16'h0DAC;
    cyc(5);
    pin_mv <= 16'h00C8;
    wait_fm(1'b1, 2600, n);
    `CHK("otp_filter", 1'b1, n >= 2500)
    pin_mv <= 16'h02BC;
    cyc(REC + 20);
    `CHK("otp_hold", 1'b1, fmode)
    pin_mv <= 16'h05DC;
    wait_fm(1'b0, 5, n);
  endtask : t_otp

  task automatic t_ovp();
    int n;
    pin_mv <= 16'h0DAC;
    cyc(620);
    pin_mv <= 16'h05DC;
    cyc(10);
    `CHK("ovp_glitch", 1'b0, fmode)
    pin_mv <= 16'h0DAC;
    wait_fm(1'b1, 700, n);
    `CHK("ovp_filter", 1'b1, n >= 625)
    n = 0;
    repeat (3 * REC) begin
      @(posedge clk);
      if (drive !== 1'b0) n++;
    end
    `CHK("ovp_held_drive", 0, n)
    `CHK("ovp_held_mode", 1'b1, fmode)
    pin_mv <= 16'h05DC;
    wait_fm(1'b0, REC + 5, n);
    `CHK("ovp_release", 1'b0, fmode)
  endtask : t_ovp

  task automatic trips(input int k);
    int t;
    for (t = 0; k > 0 && t < 200; t++) begin
      @(posedge clk);
      if (trip === 1'b1) k--;
    end
    if (k > 0) begin
      bad_count++;
      $display("BAD trip_wait exp %0h seen %0h", 0, k);
      give_verdict();
    end
  endtask : trips

  task automatic t_short();
    int n;
    short_en <= 1'b1;
    trips(3);
    short_en <= 1'b0;
    cyc(8);
    short_en <= 1'b1;
    trips(3);
    `CHK("short_restart", 1'b0, fmode)
    trips(1);
    wait_fm(1'b1, 4, n);
    short_en <= 1'b0;
    wait_fm(1'b0, REC + 5, n);
    `CHK("short_recover", 1'b1, n >= REC)
  endtask : t_short

  task automatic overload_timeout();
    int n;
    ilim_en <= 1'b1;
    wait_fm(1'b1, OVERLOAD_FAULT * 8 + 40, n);
    ilim_en <= 1'b0;
    `CHK("overload_fault_time", 1'b1, n >= (OVERLOAD_FAULT - 1) * 8)
    wait_fm(1'b0, REC + 5, n);
    `CHK("overload_fault_recover", 1'b1, n >= REC)
  endtask : overload_timeout

  task automatic t_thermal();
    temp_c <= 16'h00AA;
    cyc(3);
    `CHK("tsd_mode", 1'b1, fmode)
    `CHK("tsd_bias", 1'b1, lowp)
    `CHK("tsd_drive", 1'b0, drive)
    temp_c <= 16'h0096;
    cyc(REC + 10);
    `CHK("tsd_hyst", 1'b1, fmode)
    temp_c <= 16'h0082;
    cyc(3);
    `CHK("tsd_release", 1'b0, fmode)
  endtask : t_thermal

  task automatic t_sup();
    int n;
    for (int k = 0; k < 2; k++) begin
      sup_ovp <= 1'b1;
      wait_fm(1'b1, 400, n);
      `CHK("sup_filter", 1'b1, n >= 375)
      sup_ovp <= 1'b0;
      cyc(2 * REC);
      `CHK("sup_latch", 1'b1, fmode)
      pulse_rst(k == 0);
      `CHK("ctl_reset", 1'b0, fmode)
    end
  endtask : t_sup

  task automatic t_bus();
    int n;
    bus(1'b0, CTRL_OFS, 32'h0000_0000);
    `CHK("ctrl_reset", {30'h0000_0000, CTRL_RESET}, rd)
    bus(1'b1, CTRL_OFS, 32'h0000_0002);
    bus(1'b0, CTRL_OFS, 32'h0000_0000);
    `CHK("ctrl_rw", 32'h0000_0002, rd)
    bus(1'b0, 8'h0C, 32'h0000_0000);
    `CHK("unmapped", RDATA_ZERO, rd)
    pin_mv <= 16'h0DAC;
    wait_fm(1'b1, 700, n);
    pin_mv <= 16'h05DC;
    cyc(2 * REC);
    `CHK("ovp_latched", 1'b1, fmode)
    bus(1'b0, STATUS_OFS, 32'h0000_0000);
    `CHK("st_latch", 1'b1, rd[ST_LATCH_BIT])
    `CHK("st_cause", 1'b1, rd[FI_OVP])
    pulse_rst(1'b1);
    `CHK("latch_clear", 1'b0, fmode)
    bus(1'b0, STATUS_OFS, 32'h0000_0000);
    `CHK("st_cause_clr", 6'h00, rd[ST_CAUSE_LSB +: NUM_FAULTS])
    `CHK("st_fault_clr", 1'b0, rd[ST_FAULT_BIT])
    `CHK("st_ss", 1'b1, rd[ST_SS_BIT])
    // Every one of the six detectors has fired by now
    bus(1'b0, EVENT_OFS, 32'h0000_0000);
    `CHK("events_all", 32'h0000_003F, rd)
    bus(1'b1, EVENT_OFS, 32'h0000_003F);
    bus(1'b0, EVENT_OFS, 32'h0000_0000);
    `CHK("events_clear", RDATA_ZERO, rd)
    bus(1'b1, CTRL_OFS, 32'h0000_0000);
  endtask : t_bus

  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    cyc(2);
    t_otp();
    t_ovp();
    t_short();
    overload_timeout();
    t_thermal();
    t_sup();
    t_bus();
    give_verdict();
  end
endmodule : tb_top
